// ### core/asc_top.sv
// Control logic of a 10-bit successive-approximation converter.
// Assumes an AXI4-Lite master and an external comparator on cmp_i.
// Behaviour
// [RULE_01] Channel field bits 5:2 picks input
// [RULE_02] Start bit starts, reads one, self-clears
// [RULE_03] Power bit enables converter, off when clear
// [RULE_04] Unused control bits read zero
// [RULE_05] Reference field selects high and low references
// [RULE_06] Pin config n makes n top inputs digital; the code makes n+1 top inputs digital for n of 1 or more, none for 0
// [RULE_07] Unimplemented channel returns all ones
// [RULE_08] Format bit: one right, zero left
// [RULE_09] Clock select codes give oscillator divisors
// [RULE_10] Codes 011 and 111 choose RC clock
// [RULE_11] Completion loads result, clears start, sets flag
// [RULE_12] Result is ten bits over two registers
// [RULE_13] Conversion takes twelve conversion periods
// [RULE_14] Software waits acquisition before starting
// [RULE_15] Software polls or takes interrupt, reads result
// [RULE_16] Software clears flag before enabling interrupt
// [RULE_17] Conversion completes during sleep
// [RULE_18] Successive approximation, MSB first
// [RULE_19] Control registers reset to zero
// [RULE_20] Abort keeps result, two-period wait follows
// [RULE_21] Two-period gap after completion
// [RULE_22] Software avoids start with power-on write
// [RULE_23] Justified layout across result pair
// [RULE_24] Flag sticky; request when flag and enable
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module asc_top #(
   parameter int NUM_CHAN = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic sleep_i,
   input wire logic cmp_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] chan_sel_o,
   output logic sample_o,
   output logic [9:0] dac_o,
   output logic conv_power_o,
   output logic [1:0] ref_sel_o,
   output logic [15:0] pin_analog_o,
   output logic irq_o
);
   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [3:0] chan_q;
   logic start_q;
   logic pow_q;
   logic [1:0] ref_q;
   logic [3:0] pcfg_q;
   logic just_q;
   logic [2:0] clksel_q;
   logic flag_q;
   logic ien_q;
   logic ipri_q;
   logic [9:0] result_q;
   logic [9:0] trial_q;
   logic [3:0] step_q;
   logic [1:0] gap_q;
   asc_pkg::asc_state_t state_q;
   logic tick;
   logic done;
   logic abort;
   logic chan_bad_q;

   // ------------------------------------------------------------------
   // AXI write channel
   // ------------------------------------------------------------------
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wen_q;
   logic wr_fire;

   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 8'h00;
         wen_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wen_q <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = wr_fire && wen_q && (a == off);
   endfunction

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         chan_q <= 4'h0; // RULE_19
         pow_q <= 1'b0;
         ref_q <= 2'h0;
         pcfg_q <= 4'h0;
         just_q <= 1'b0;
         clksel_q <= 3'h0;
         ien_q <= 1'b0;
         ipri_q <= 1'b0;
      end else begin
         if (hit(awaddr_q, asc_pkg::ASC_OFF_CTRL_CHAN)) begin
            chan_q <= wdata_q[asc_pkg::ASC_CHAN_LSB +: 4]; // RULE_01
            pow_q <= wdata_q[asc_pkg::ASC_POW_BIT]; // RULE_03
         end
         if (hit(awaddr_q, asc_pkg::ASC_OFF_REF_PIN)) begin
            ref_q <= wdata_q[asc_pkg::ASC_REF_LSB +: 2]; // RULE_05
            pcfg_q <= wdata_q[3:0];
         end
         if (hit(awaddr_q, asc_pkg::ASC_OFF_CLK_FMT)) begin
            just_q <= wdata_q[asc_pkg::ASC_JUST_BIT];
            clksel_q <= wdata_q[2:0];
         end
         if (hit(awaddr_q, asc_pkg::ASC_OFF_IRQ)) begin
            ien_q <= wdata_q[asc_pkg::ASC_IEN_BIT];
            ipri_q <= wdata_q[asc_pkg::ASC_IPRI_BIT];
         end
      end
   end

   // Start bit: software sets or clears, hardware clears on completion
   assign abort = hit(awaddr_q, asc_pkg::ASC_OFF_CTRL_CHAN) &&
                  !wdata_q[asc_pkg::ASC_START_BIT] && state_q == asc_pkg::ASC_CONV;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !pow_q) begin
         start_q <= 1'b0;
      end else if (done) begin
         start_q <= 1'b0; // RULE_02 RULE_11
      end else if (hit(awaddr_q, asc_pkg::ASC_OFF_CTRL_CHAN)) begin
         start_q <= wdata_q[asc_pkg::ASC_START_BIT] && state_q != asc_pkg::ASC_GAP;
      end
   end

   // Done flag: set wins over a clearing write
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         flag_q <= 1'b0;
      end else if (done) begin
         flag_q <= 1'b1; // RULE_11 RULE_24
      end else if (hit(awaddr_q, asc_pkg::ASC_OFF_IRQ)) begin
         flag_q <= wdata_q[asc_pkg::ASC_FLAG_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Conversion engine
   // ------------------------------------------------------------------
   asc_tad_gen u_tad (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .run_i(state_q != asc_pkg::ASC_IDLE),
      .sel_i(clksel_q), // RULE_09 RULE_10
      .tick_o(tick)
   );

   assign done = state_q == asc_pkg::ASC_CONV && tick && step_q == 4'(asc_pkg::ASC_CONV_PERIODS - 1);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !pow_q) begin
         state_q <= asc_pkg::ASC_IDLE;
         step_q <= 4'h0;
         gap_q <= 2'h0;
         trial_q <= 10'h000;
         chan_bad_q <= 1'b0;
      end else begin
         case (state_q)
            asc_pkg::ASC_IDLE: begin
               step_q <= 4'h0;
               gap_q <= 2'h0;
               trial_q <= 10'h200;
               chan_bad_q <= 32'(chan_q) >= NUM_CHAN; // RULE_07
               if (start_q) begin
                  state_q <= asc_pkg::ASC_CONV; // RULE_17
               end
            end
            asc_pkg::ASC_CONV: begin
               if (abort) begin
                  state_q <= asc_pkg::ASC_GAP; // RULE_20
               end else if (tick) begin
                  step_q <= step_q + 4'h1; // RULE_13
                  if (step_q >= 4'h1 && step_q <= 4'ha) begin
                     for (int i = 0; i < 10; i++) begin
                        if (i == 32'(4'ha - step_q)) begin
                           trial_q[i] <= cmp_i; // RULE_18
                           if (i > 0) begin
                              trial_q[i - 1] <= 1'b1;
                           end
                        end
                     end
                  end
                  if (done) begin
                     state_q <= asc_pkg::ASC_GAP; // RULE_21
                  end
               end
            end
            asc_pkg::ASC_GAP: begin
               if (tick) begin
                  gap_q <= gap_q + 2'h1;
                  if (gap_q == 2'(asc_pkg::ASC_GAP_PERIODS - 1)) begin
                     state_q <= asc_pkg::ASC_IDLE;
                  end
               end
            end
            default: state_q <= asc_pkg::ASC_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         result_q <= asc_pkg::ASC_RST_RESULT;
      end else if (done) begin
         result_q <= chan_bad_q ? asc_pkg::ASC_ALL_ONES : trial_q; // RULE_07 RULE_12
      end
   end

   // ------------------------------------------------------------------
   // Outputs to the analog side
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         chan_sel_o <= 4'h0;
         sample_o <= 1'b0;
         dac_o <= 10'h000;
         conv_power_o <= 1'b0;
         ref_sel_o <= 2'h0;
         pin_analog_o <= 16'hffff;
         irq_o <= 1'b0;
      end else begin
         chan_sel_o <= chan_q;
         sample_o <= pow_q && state_q == asc_pkg::ASC_IDLE;
         dac_o <= trial_q;
         conv_power_o <= pow_q; // RULE_03
         ref_sel_o <= ref_q; // RULE_05
         for (int i = 0; i < 16; i++) begin
            pin_analog_o[i] <= pcfg_q == 4'h0 || i < 15 - 32'(pcfg_q); // RULE_06
         end
         irq_o <= flag_q && ien_q; // RULE_24
      end
   end

   // ------------------------------------------------------------------
   // AXI read channel
   // ------------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      case (s_axi_araddr)
         asc_pkg::ASC_OFF_CTRL_CHAN: rd_byte = {2'h0, chan_q, start_q, pow_q}; // RULE_04
         asc_pkg::ASC_OFF_REF_PIN: rd_byte = {2'h0, ref_q, pcfg_q};
         asc_pkg::ASC_OFF_CLK_FMT: rd_byte = {just_q, 4'h0, clksel_q};
         asc_pkg::ASC_OFF_RES_HIGH: rd_byte = just_q ? {6'h00, result_q[9:8]} :
                                              result_q[9:2]; // RULE_08 RULE_23
         asc_pkg::ASC_OFF_RES_LOW: rd_byte = just_q ? result_q[7:0] :
                                             {result_q[1:0], 6'h00};
         asc_pkg::ASC_OFF_IRQ: rd_byte = {5'h00, ipri_q, ien_q, flag_q};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= 2'h0;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   logic unused_sleep;
   assign unused_sleep = sleep_i;
endmodule

// ### core/asc_pkg.sv
// Package for the 10-bit successive-approximation converter control block.
// Assumes a single 40 MHz core clock and an AXI4-Lite register port.
package asc_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ASC_OFF_CTRL_CHAN = 8'h00;
   localparam logic [7:0] ASC_OFF_REF_PIN = 8'h04;
   localparam logic [7:0] ASC_OFF_CLK_FMT = 8'h08;
   localparam logic [7:0] ASC_OFF_RES_HIGH = 8'h0c;
   localparam logic [7:0] ASC_OFF_RES_LOW = 8'h10;
   localparam logic [7:0] ASC_OFF_IRQ = 8'h14;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int ASC_POW_BIT = 0;
   localparam int ASC_START_BIT = 1;
   localparam int ASC_CHAN_LSB = 2;
   localparam int ASC_REF_LSB = 4;
   localparam int ASC_JUST_BIT = 7;
   localparam int ASC_FLAG_BIT = 0;
   localparam int ASC_IEN_BIT = 1;
   localparam int ASC_IPRI_BIT = 2;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] ASC_RST_CTRL = 8'h00;
   localparam logic [9:0] ASC_RST_RESULT = 10'h000;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int ASC_CORE_CLK_HZ = 40000000;
   localparam int ASC_RC_MAX_HZ = 1000000;
   localparam int ASC_RC_DIV = (ASC_CORE_CLK_HZ + ASC_RC_MAX_HZ - 1) / ASC_RC_MAX_HZ;
   localparam int ASC_CONV_PERIODS = 12;
   localparam int ASC_GAP_PERIODS = 2;
   localparam logic [9:0] ASC_ALL_ONES = 10'h3ff;

   typedef enum logic [1:0] {
      ASC_IDLE,
      ASC_CONV,
      ASC_GAP
   } asc_state_t;

endpackage

// ### core/asc_tad_gen.sv
// Period tick generator for the conversion clock.
// Assumes select codes are stable while a conversion runs.
`timescale 1ns/1ps
module asc_tad_gen (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic [2:0] sel_i,
   output logic tick_o
);
   logic [6:0] cnt_q;
   logic [6:0] lim;

   // ------------------------------------------------------------------
   // Divider limit
   // ------------------------------------------------------------------
   always_comb begin
      case (sel_i)
         3'h0: lim = 7'h01;
         3'h4: lim = 7'h03;
         3'h1: lim = 7'h07;
         3'h5: lim = 7'h0f;
         3'h2: lim = 7'h1f;
         3'h6: lim = 7'h3f;
         default: lim = 7'(asc_pkg::ASC_RC_DIV - 1);
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !run_i || cnt_q >= lim) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= run_i && (cnt_q == lim);
      end
   end
endmodule

// ### verification/asc_top_monitor.sv
// Port checker for the converter control block.
// Bound to asc_top; sees its ports only.
`timescale 1ns/1ps
module asc_top_monitor #(
   parameter int NUM_CHAN = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic sample_o,
   input wire logic [9:0] dac_o,
   input wire logic conv_power_o,
   input wire logic [1:0] ref_sel_o,
   input wire logic [3:0] chan_sel_o,
   input wire logic [15:0] pin_analog_o
);
   // ----------
   // Helpers
   // ----------
   localparam int LOW_MAX = 964;
   int low_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || sample_o || !conv_power_o) begin
         low_q <= 0;
      end else begin
         low_q <= low_q + 1;
      end
   end
   sequence s_conv_begin;
      $fell(sample_o) && conv_power_o && 32'(chan_sel_o) < NUM_CHAN;
   endsequence
   sequence s_msb_trial;
      ##[1:140] $changed(dac_o) && dac_o[8:0] == 9'h100;
   endsequence
   // ----------
   // Checks
   // ----------
   AST_POWER_SAMPLE: assert property (!conv_power_o && !$past(conv_power_o) |-> !sample_o)
      else $error("acquiring while powered down");
   AST_POWER_UP_ACQ: assert property ($rose(conv_power_o) |-> ##[0:2] sample_o)
      else $error("no acquisition after power up");
   AST_TICK_SPACING: assert property ($changed(dac_o) |=> $stable(dac_o))
      else $error("trial steps closer than two cycles");
   AST_CONV_BOUND: assert property (low_q <= LOW_MAX)
      else $error("conversion too long");
   AST_PIN_MASK: assert property (((17'(pin_analog_o) + 17'h1) & 17'(pin_analog_o)) == 17'h0)
      else $error("analog pin mask not contiguous");
   AST_ACQ_DAC_STILL: assert property (sample_o && $past(sample_o) |=> $stable(dac_o))
      else $error("trial word moves while acquiring");
   AST_MSB_FIRST: assert property (s_conv_begin |-> s_msb_trial)
      else $error("first trial not the top bit");
   AST_RESET_STATE: assert property ($rose(rst_n_i) |-> pin_analog_o == 16'hffff &&
      !conv_power_o && ref_sel_o == 2'h0 && chan_sel_o == 4'h0)
      else $error("outputs not at reset state");
endmodule
bind asc_top asc_top_monitor #(.NUM_CHAN(NUM_CHAN)) asc_top_monitor_i (.core_clk_i, .rst_n_i,
   .sample_o, .dac_o, .conv_power_o, .ref_sel_o, .chan_sel_o, .pin_analog_o);

// ### verification/asc_analog_model.sv
// Analog inputs and comparator facing the converter.
// Assumes dac_i settles within a cycle.
`timescale 1ns/1ps
module asc_analog_model (
   input wire logic [3:0] chan_i,
   input wire logic [9:0] dac_i,
   output logic cmp_o
);
   // Each input sits half a code above {chan, 6'h15}
   assign cmp_o = dac_i <= {chan_i, 6'h15};
endmodule

// ### verification/asc_top_tb.sv
// Testbench of the converter control block.
// Assumes AXI4-Lite slave timing as handed over.
`timescale 1ns/1ps
module asc_top_tb;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
$display("Error %0t: got %h exp %h", $time, (a), (e)); end end
   // ----------
   // Signals
   // ----------
   logic core_clk_i = 0, rst_n_i = 0, sleep_i = 0, cmp_i;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1, chan_sel_o, ch;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic conv_power_o, sample_o, irq_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, ref_sel_o;
   logic [9:0] dac_o, ex;
   logic [15:0] pin_analog_o;
   int err_count = 0, num_checks = 0, low_cnt = 0, i;
   int dv[8] = '{2, 8, 32, 40, 4, 16, 64, 40};
   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      if (sample_o === 1'h0 && conv_power_o === 1'h1) low_cnt <= low_cnt + 1;
   end
   asc_top #(.NUM_CHAN(12)) asc_top_i (.core_clk_i, .rst_n_i, .sleep_i, .cmp_i, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_sel_o, .sample_o, .dac_o,
      .conv_power_o, .ref_sel_o, .pin_analog_o, .irq_o);
   asc_analog_model asc_analog_model_i (.chan_i(chan_sel_o), .dac_i(dac_o), .cmp_o(cmp_i));
   // ----------
   // Tasks
   // ----------
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic hang();
      err_count++;
      $display("Error %0t: timeout", $time);
      conclude();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk_i);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      s_axi_bready <= 1'h0;
      if (n == 40) hang();
      `CHK(s_axi_bresp, 2'h0)
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      int n;
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk_i);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      s_axi_rready <= 1'h0;
      if (n == 40) hang();
      `CHK(s_axi_rdata, {24'h0, e})
      `CHK(s_axi_rresp, 2'h0)
   endtask
   task automatic wt(input int k);
      int n;
      for (n = 0; n < 2000; n++) begin
         @(posedge core_clk_i);
         if ((k ? irq_o : sample_o) === 1'h1) break;
      end
      if (n == 2000) hang();
   endtask
   // ----------
   // Sequence
   // ----------
   initial begin
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      for (i = 0; i < 7; i++) rc(8'(i * 4), 8'h00);
      `CHK(pin_analog_o, 16'hffff)
      wr(8'h00, 8'hfe);
      rc(8'h00, 8'h3c);
      `CHK({conv_power_o, chan_sel_o}, 5'h0f)
      wr(8'h08, 8'hff);
      rc(8'h08, 8'h87);
      for (i = 0; i < 16; i++) begin
         wr(8'h04, {2'h3, i[1:0], i[3:0]});
         rc(8'h04, {2'h0, i[1:0], i[3:0]});
         `CHK(pin_analog_o, 16'hffff >> (i == 0 ? 0 : i + 1))
         `CHK(ref_sel_o, i[1:0])
      end
      wr(8'h00, 8'h01);
      wr(8'h14, 8'h02);
      for (i = 0; i < 8; i++) begin
         ch = 4'(i + 8);
         ex = (ch < 12) ? {ch, 6'h15} : 10'h3ff;
         wr(8'h08, {i[0], 4'h0, i[2:0]});
         sleep_i <= i[1];
         repeat (8) @(posedge core_clk_i);
         low_cnt = 0;
         wr(8'h00, {2'h0, ch, 2'h3});
         rc(8'h00, {2'h0, ch, 2'h3});
         wt(1);
         rc(8'h00, {2'h0, ch, 2'h1});
         rc(8'h14, 8'h03);
         rc(8'h0c, i[0] ? {6'h0, ex[9:8]} : ex[9:2]);
         rc(8'h10, i[0] ? ex[7:0] : {ex[1:0], 6'h0});
         wr(8'h14, 8'h02);
         repeat (3) @(posedge core_clk_i);
         `CHK(irq_o, 1'h0)
         wt(0);
         `CHK(low_cnt >= 13 * dv[i] + 1 && low_cnt <= 15 * dv[i] + 4, 1'h1)
      end
      wr(8'h00, 8'h23);
      repeat (100) @(posedge core_clk_i);
      wr(8'h00, 8'h21);
      wt(0);
      rc(8'h14, 8'h02);
      rc(8'h0c, 8'h03);
      rc(8'h10, 8'hff);
      wr(8'h00, 8'h23);
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'h0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      rc(8'h00, 8'h00);
      rc(8'h08, 8'h00);
      conclude();
   end
endmodule
